// ### core/tafs_status.v
// Frame status zero register with APB slave and flag tracking
//
// Notes on behaviour
// - Low four bits give buffer size code
// - Buffer size ignores writes, reads last load
// - Code loaded from control block on join
// - Short flag set when length equals eight
// - Ack pending set on reception needing reply
// - Ack pending cleared after ack sent
// - Final flag marks last frame this period
// - Five listed events set the final flag
// - End of queue never sets final flag
// - Piggyback token appended on the final frame when permitted, no ack
// - Final flag held until next frame starts
// - Bits: final, ack, short, zero, size
//
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "tafs_defs.vh"
module tafs_status #(
   parameter FRAME_LIMIT_W = 8
) (
   input  wire                     pclk,
   input  wire                     presetn,
   input  wire                     psel,
   input  wire                     penable,
   input  wire                     pwrite,
   input  wire [11:0]              paddr,
   input  wire [31:0]              pwdata,
   output reg  [31:0]              prdata,
   output reg                      pready,
   output reg                      pslverr,
   input  wire                     cblock_valid,
   input  wire [3:0]               cblock_bsize,
   input  wire                     tx_frame_start,
   input  wire                     tx_active,
   input  wire [15:0]              tx_length,
   input  wire                     tx_underrun,
   input  wire                     tx_fsb_last,
   input  wire                     tx_fsb_noack,
   input  wire [FRAME_LIMIT_W-1:0] token_frame_count,
   input  wire                     rx_frame_ack_needed,
   input  wire                     ack_frame_sent,
   output reg                      append_token,
   output reg                      leave_isolate,
   output reg                      piggyback_permit,
   output reg                      transmit_data_enable,
   output reg                      isolate_request
);
   reg  [3:0]               buffer_size_code;
   reg                      short_frame_flag;
   reg                      ack_pending_flag;
   reg                      final_frame_flag;
   reg  [FRAME_LIMIT_W-1:0] token_frame_limit;
   reg                      joined;
   wire                     isolate_request_rise;
   wire                     transmit_data_enable_fall_n;
   wire                     transmit_data_enable_fall;
   wire                     setup_phase;
   wire                     access_write;
   wire                     addr_ok;
   wire                     limit_hit;
   wire                     final_set;
   wire [7:0]               status_byte;

   tafs_edge #(
      .IDLE    (1'b1)
   ) u_isolate_request (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (isolate_request),
      .rise    (isolate_request_rise)
   );

   tafs_edge #(
      .IDLE    (1'b1)
   ) u_transmit_data_enable (
      .pclk    (pclk),
      .presetn (presetn),
      .level   (~transmit_data_enable),
      .rise    (transmit_data_enable_fall_n)
   );
   assign transmit_data_enable_fall = transmit_data_enable_fall_n;

   assign setup_phase  = psel & ~penable;
   assign access_write = psel & penable & pready & pwrite;
   assign addr_ok      = (paddr == `TAFS_ADDR_STATUS0) | (paddr == `TAFS_ADDR_CONFIG) |
                         (paddr == `TAFS_ADDR_CBLOCK) | (paddr == `TAFS_ADDR_EVENT);
   assign limit_hit    = (token_frame_count >= token_frame_limit);

   assign status_byte = {final_frame_flag, ack_pending_flag, short_frame_flag, 1'b0, buffer_size_code};

   assign final_set = tx_active & (isolate_request_rise | transmit_data_enable_fall | tx_fsb_last | limit_hit | tx_underrun);

   // APB slave, no wait states
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h00000000;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase & ~addr_ok;
         if (setup_phase) begin
            case (paddr)
               `TAFS_ADDR_STATUS0: prdata <= {24'h000000, status_byte};
               `TAFS_ADDR_CONFIG:  prdata <= {29'h00000000, isolate_request, transmit_data_enable,
                                              piggyback_permit};
               `TAFS_ADDR_EVENT:   prdata <= {{(32-FRAME_LIMIT_W){1'b0}}, token_frame_limit};
               `TAFS_ADDR_CBLOCK:  prdata <= {31'h00000000, joined};
               default:            prdata <= 32'h00000000;
            endcase
         end else begin
            prdata <= 32'h00000000;
         end
      end
   end

   // Control bits written by software
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         piggyback_permit     <= 1'b0;
         transmit_data_enable <= 1'b0;
         isolate_request      <= 1'b1;
         token_frame_limit    <= `TAFS_FRAME_LIMIT_DEF;
      end else if (access_write) begin
         if (paddr == `TAFS_ADDR_CONFIG) begin
            piggyback_permit     <= pwdata[`TAFS_CFG_PIGGY];
            transmit_data_enable <= pwdata[`TAFS_CFG_TRANSMIT_DATA_ENABLE];
            isolate_request      <= pwdata[`TAFS_CFG_ISOLATE_REQUEST];
         end
         if (paddr == `TAFS_ADDR_EVENT) begin
            token_frame_limit <= pwdata[FRAME_LIMIT_W-1:0];
         end
      end
   end

   // Isolate to network transition and code load
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         joined           <= 1'b0;
         leave_isolate    <= 1'b0;
         buffer_size_code <= `TAFS_BSIZE_RESET;
      end else begin
         leave_isolate <= ~isolate_request & ~joined & ~leave_isolate;
         if (isolate_request) begin
            joined <= 1'b0;
         end else if (leave_isolate & cblock_valid) begin
            joined <= 1'b1;
            buffer_size_code <= cblock_bsize;
         end
      end
   end

   // Transmit and receive flags
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         short_frame_flag <= 1'b0;
         ack_pending_flag <= 1'b0;
         final_frame_flag <= 1'b0;
         append_token     <= 1'b0;
      end else begin
         if (tx_frame_start) begin
            short_frame_flag <= (tx_length == `TAFS_SHORT_LEN);
         end else if (tx_active & (tx_length == `TAFS_SHORT_LEN)) begin
            short_frame_flag <= 1'b1;
         end
         if (rx_frame_ack_needed) begin
            ack_pending_flag <= 1'b1;
         end else if (ack_frame_sent) begin
            ack_pending_flag <= 1'b0;
         end
         if (final_set) begin
            final_frame_flag <= 1'b1;
         end else if (tx_frame_start) begin
            final_frame_flag <= 1'b0;
         end
         append_token <= tx_active & (final_set | final_frame_flag) & piggyback_permit & tx_fsb_noack;
      end
   end
endmodule

// ### core/tafs_defs.vh
// Constants for the frame status zero register block
`ifndef TAFS_DEFS_VH
`define TAFS_DEFS_VH
`define TAFS_ADDR_STATUS0    12'h000
`define TAFS_ADDR_EVENT      12'h004
`define TAFS_ADDR_CONFIG     12'h008
`define TAFS_ADDR_CBLOCK     12'h00c
`define TAFS_BIT_FINAL       7
`define TAFS_BIT_ACK         6
`define TAFS_BIT_SHORT       5
`define TAFS_BIT_ZERO        4
`define TAFS_SHORT_LEN       16'h0008
`define TAFS_BSIZE_RESET     4'h0
`define TAFS_FRAME_LIMIT_DEF 8'h08
`define TAFS_CFG_PIGGY       0
`define TAFS_CFG_TRANSMIT_DATA_ENABLE       1
`define TAFS_CFG_ISOLATE_REQUEST        2
`endif

// ### core/tafs_edge.v
// Rising edge detector for a same-clock level
`timescale 1ns/1ps
module tafs_edge #(
   parameter [0:0] IDLE = 1'b0
) (
   input  wire pclk,
   input  wire presetn,
   input  wire level,
   output wire rise
);
   reg last;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last <= IDLE;
      end else begin
         last <= level;
      end
   end
   assign rise = level & ~last;
endmodule

// ### verif/tafs_status_assertions.sv
// Checker of bus and join behaviour
`timescale 1ns/1ps
module tafs_status_assertions (
   input logic        pclk,
   input logic        presetn,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        leave_isolate,
   input logic        isolate_request,
   input logic        transmit_data_enable
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("no ready");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_rdz; !pready |-> prdata == 32'h0; endproperty
   a_rdz: assert property (p_rdz) else $error("stray data");
   property p_err; pready |-> pslverr == !(paddr inside {12'h0, 12'h4, 12'h8, 12'hc}); endproperty
   a_err: assert property (p_err) else $error("bad error");
   property p_zero; pready && !pwrite && paddr == 12'h0 |-> prdata[31:8] == 24'h0 && !prdata[4]; endproperty
   a_zero: assert property (p_zero) else $error("bad bits");
   property p_txd; pready && pwrite && paddr == 12'h8 && pwdata[1] |=> transmit_data_enable; endproperty
   a_txd: assert property (p_txd) else $error("no enable");
   property p_lv; $fell(isolate_request) |=> leave_isolate; endproperty
   a_lv: assert property (p_lv) else $error("no fetch");
   property p_lv1; leave_isolate |=> !leave_isolate; endproperty
   a_lv1: assert property (p_lv1) else $error("long fetch");
   cover property (pready && pslverr);
   cover property (leave_isolate);
   cover property (pready && paddr == 12'h0 && prdata[7]);
endmodule

// ### verif/tafs_host.sv
// Host memory model serving the control block
`timescale 1ns/1ps
module tafs_host (
   input  logic       pclk,
   input  logic       presetn,
   input  logic       leave_isolate,
   output logic       cblock_valid,
   output logic [3:0] cblock_bsize
);
   always @(posedge pclk or negedge presetn)
      if (!presetn) cblock_valid <= 1'b0;
      else if (leave_isolate) cblock_valid <= 1'b1;
   assign cblock_bsize = cblock_valid ? 4'ha : 4'h5;
endmodule

// ### verif/token_access_frame_status_tb.sv
// Testbench of the frame status zero register
`timescale 1ns/1ps
module token_access_frame_status_tb;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        act = 0, und = 0, last = 0, pready, pslverr, cv, er, lv;
   logic        noack = 0, app, pp;
   logic [2:0]  pu = 3'h0;
   logic [3:0]  cb;
   logic [7:0]  cnt = 8'h00;
   logic [11:0] paddr = 12'h0;
   logic [15:0] len = 16'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   int          n_errors = 0, samples_checked = 0;
   tafs_status DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .cblock_valid(cv), .cblock_bsize(cb), .tx_frame_start(pu[0]), .tx_active(act), .tx_length(len),
      .tx_underrun(und), .tx_fsb_last(last), .tx_fsb_noack(noack), .token_frame_count(cnt),
      .rx_frame_ack_needed(pu[1]), .ack_frame_sent(pu[2]), .append_token(app), .leave_isolate(lv),
      .piggyback_permit(pp), .transmit_data_enable(), .isolate_request());
   tafs_host HOST (.pclk, .presetn, .leave_isolate(lv), .cblock_valid(cv), .cblock_bsize(cb));
   initial forever #2.5 pclk = ~pclk;
   task test_done;
      $display("errors %0d checks %0d", n_errors, samples_checked);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", n, e, g);
         n_errors++;
      end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      i = 0;
      do begin
         @(posedge pclk);
         i++;
      end while (pready !== 1'b1 && i < 20);
      {rd, er} = {prdata, pslverr};
      if (pready !== 1'b1) begin
         n_errors++;
         test_done;
      end
      {psel, penable} <= 2'b00;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk("prdata", e, rd);
   endtask
   task pls(input logic [2:0] m);
      @(posedge pclk);
      pu <= m;
      @(posedge pclk);
      pu <= 3'h0;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      rdc(12'h000, 32'h0);
      rdc(12'h008, 32'h4);
      rdc(12'h004, 32'h8);
      xfer(1'b0, 12'h010, 32'h0);
      chk("pslverr", 32'h1, {31'h0, er});
      xfer(1'b1, 12'h008, 32'h2);
      for (int k = 0; k < 10 && rd[0] !== 1'b1; k++) xfer(1'b0, 12'h00c, 32'h0);
      chk("joined", 32'h1, rd);
      xfer(1'b1, 12'h000, 32'hff);
      rdc(12'h000, 32'h0a);
      $display("test join done");
      {act, len} <= {1'b1, 16'h0008};
      pls(3'h1);
      rdc(12'h000, 32'h2a);
      last <= 1'b1;
      rdc(12'h000, 32'haa);
      {last, len} <= {1'b0, 16'h0064};
      pls(3'h1);
      rdc(12'h000, 32'h0a);
      for (int k = 0; k < 2; k++) begin
         {und, cnt} <= k ? {1'b0, 8'h08} : {1'b1, 8'h00};
         rdc(12'h000, 32'h8a);
         {und, cnt} <= 9'h000;
         pls(3'h1);
         rdc(12'h000, 32'h0a);
      end
      pls(3'h2);
      rdc(12'h000, 32'h4a);
      pls(3'h4);
      rdc(12'h000, 32'h0a);
      $display("test flags done");
      xfer(1'b1, 12'h008, 32'h3);
      {noack, last} <= 2'b11;
      rdc(12'h000, 32'h8a);
      chk("piggyback_permit", 32'h1, {31'h0, pp});
      chk("append_token", 32'h1, {31'h0, app});
      {noack, last} <= 2'b00;
      pls(3'h1);
      rdc(12'h000, 32'h0a);
      chk("append_token", 32'h0, {31'h0, app});
      xfer(1'b1, 12'h008, 32'h1);
      rdc(12'h000, 32'h8a);
      chk("append_token", 32'h0, {31'h0, app});
      pls(3'h1);
      rdc(12'h000, 32'h0a);
      xfer(1'b1, 12'h008, 32'h5);
      rdc(12'h000, 32'h8a);
      $display("test piggyback done");
      test_done;
   end
endmodule
bind tafs_status tafs_status_assertions CHK (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr, .leave_isolate, .isolate_request, .transmit_data_enable);
